// File: verilog/mac_stats_params.svh
`ifndef MAC_STATS_PARAMS_SVH
`define MAC_STATS_PARAMS_SVH

// width of one increment vector
`define INC_W          25

// bit positions inside an increment vector
`define INC_64         0
`define INC_127        1
`define INC_255        2
`define INC_511        3
`define INC_1023       4
`define INC_1518       5
`define INC_MAX        6
`define INC_OVER       7
`define INC_MC_DATA_E  8
`define INC_MC_DATA_O  9
`define INC_BC_DATA_E  10
`define INC_BC_DATA_O  11
`define INC_UC_DATA_E  12
`define INC_UC_DATA_O  13
`define INC_MC_CTRL    14
`define INC_BC_CTRL    15
`define INC_UC_CTRL    16
`define INC_PAUSE      17
`define INC_FCS_ERR    18
`define INC_FRAGMENT   19
`define INC_JABBER     20
`define INC_SIZEOK_FCS 21
`define INC_RUNT       22
`define INC_SPARE0     23
`define INC_SPARE1     24

// length bin limits in bytes
`define LEN_64         16'h0040
`define LEN_127        16'h007F
`define LEN_255        16'h00FF
`define LEN_511        16'h01FF
`define LEN_1023       16'h03FF
`define LEN_1518       16'h05EE

// default maximum legal frame length in bytes
`define MAX_LEN_DEF    16'h05EE

// reset value of every increment vector
`define INC_RST        25'h0000000

`endif

// File: verilog/mac_stats_pkg.sv
`default_nettype none
package mac_stats_pkg;
`include "mac_stats_params.svh"

    // complete state of the increment generator
    typedef struct packed {
        logic [`INC_W-1:0] tx_inc;    // tx pulses to the top level
        logic [`INC_W-1:0] rx_inc;    // rx pulses to the top level
        logic [`INC_W-1:0] csr_tx;    // tx pulses to the counter block
        logic [`INC_W-1:0] csr_rx;    // rx pulses to the counter block
    } state_type;

endpackage : mac_stats_pkg
`default_nettype wire

// File: verilog/mac_stats_increment_pulses.sv
// Overview of operation
// RULE1: all pulses always appear as top outputs; the tx runt bit 22 reaches only csr_tx_inc
// RULE2: counter option also feeds pulses to counters
// RULE3: tx and rx pulses generated on clk
// RULE4: tx bins 64 and 65-127 pulse once
// RULE5: tx bins 128-255 and 256-511 pulse once
// RULE6: tx bins 512-1023 and 1024-1518 pulse once
// RULE7: tx maximum-size and oversize pulses
// RULE8: tx multicast data errored and valid pulses
// RULE9: tx broadcast data errored and valid pulses
// RULE10: tx unicast data errored and valid pulses
// RULE11: tx control-class pulses per address type
// RULE12: tx valid pause frame pulse
// RULE13: tx frame check error pulse
// RULE14: tx fragment: under 64 with crc error
// RULE15: tx jabber: oversize with crc error
// RULE16: tx valid size with fcs error pulse
// RULE17: rx runt packet pulse
// RULE18: rx bins 64 and 65-127 pulse once
// RULE19: rx bins 128-255 and 256-511 pulse once
// RULE20: rx bins 512-1023 and 1024-1518 pulse once
// RULE21: rx maximum-size and oversize pulses
// RULE22: rx multicast/broadcast errored, multicast valid pulses
// RULE23: rx broadcast valid data pulse
// RULE24: rx unicast data errored and valid pulses
// RULE25: rx fcs pulse independent of client stream
// RULE26: rx fragment: under 64 with crc error
// RULE27: one-cycle high pulse, once per frame
`timescale 1ns/1ps
`default_nettype none
`include "mac_stats_params.svh"
module mac_stats_increment_pulses
    import mac_stats_pkg::*;
#(
    parameter int                  LEN_W    = 16,           // frame length width
    parameter logic [LEN_W-1:0]    MAX_LEN  = `MAX_LEN_DEF, // maximum legal length
    parameter bit                  STATS_EN = 1'b1          // counter module built
) (
    input  wire logic              clk,                 // mac clock
    input  wire logic              reset_n,             // async reset, active low
    // tx frame report, one cycle at end of frame
    input  wire logic              tx_frame_done,       // tx frame finished
    input  wire logic [LEN_W-1:0]  tx_frame_len,        // tx length in bytes
    input  wire logic              tx_is_mcast,         // tx multicast address
    input  wire logic              tx_is_bcast,         // tx broadcast address
    input  wire logic              tx_is_ctrl,          // tx control frame
    input  wire logic              tx_is_pause,         // tx pause frame
    input  wire logic              tx_fcs_err,          // tx crc error
    // rx frame report, one cycle when mac has checked fcs
    input  wire logic              rx_frame_done,       // rx frame finished
    input  wire logic [LEN_W-1:0]  rx_frame_len,        // rx length in bytes
    input  wire logic              rx_is_mcast,         // rx multicast address
    input  wire logic              rx_is_bcast,         // rx broadcast address
    input  wire logic              rx_is_ctrl,          // rx control frame
    input  wire logic              rx_is_pause,         // rx pause frame
    input  wire logic              rx_fcs_err,          // rx crc error
    // tx increment pulses
    output logic                   tx_inc_64,           // 64 bytes
    output logic                   tx_inc_127,          // 65-127 bytes
    output logic                   tx_inc_255,          // 128-255 bytes
    output logic                   tx_inc_511,          // 256-511 bytes
    output logic                   tx_inc_1023,         // 512-1023 bytes
    output logic                   tx_inc_1518,         // 1024-1518 bytes
    output logic                   tx_inc_max,          // maximum size
    output logic                   tx_inc_over,         // oversize
    output logic                   tx_inc_mcast_data_e, // errored multicast data
    output logic                   tx_inc_mcast_data_o, // valid multicast data
    output logic                   tx_inc_bcast_data_e, // errored broadcast data
    output logic                   tx_inc_bcast_data_o, // valid broadcast data
    output logic                   tx_inc_ucast_data_e, // errored unicast data
    output logic                   tx_inc_ucast_data_o, // valid unicast data
    output logic                   tx_inc_mcast_ctrl,   // valid multicast
    output logic                   tx_inc_bcast_ctrl,   // valid broadcast
    output logic                   tx_inc_ucast_ctrl,   // valid unicast
    output logic                   tx_inc_pause,        // valid pause
    output logic                   tx_inc_fcs_err,      // fcs error
    output logic                   tx_inc_fragment,     // short with crc error
    output logic                   tx_inc_jabber,       // oversize with crc error
    output logic                   tx_inc_sizeok_fcser, // good size, fcs error
    // rx increment pulses
    output logic                   rx_inc_runt,         // runt packet
    output logic                   rx_inc_64,           // 64 bytes
    output logic                   rx_inc_127,          // 65-127 bytes
    output logic                   rx_inc_255,          // 128-255 bytes
    output logic                   rx_inc_511,          // 256-511 bytes
    output logic                   rx_inc_1023,         // 512-1023 bytes
    output logic                   rx_inc_1518,         // 1024-1518 bytes
    output logic                   rx_inc_max,          // maximum size
    output logic                   rx_inc_over,         // oversize
    output logic                   rx_inc_mcast_data_e, // errored multicast data
    output logic                   rx_inc_mcast_data_o, // valid multicast data
    output logic                   rx_inc_bcast_data_e, // errored broadcast data
    output logic                   rx_inc_bcast_data_o, // valid broadcast data
    output logic                   rx_inc_ucast_data_e, // errored unicast data
    output logic                   rx_inc_ucast_data_o, // valid unicast data
    output logic                   rx_inc_mcast_ctrl,   // valid multicast
    output logic                   rx_inc_bcast_ctrl,   // valid broadcast
    output logic                   rx_inc_ucast_ctrl,   // valid unicast
    output logic                   rx_inc_pause,        // valid pause
    output logic                   rx_inc_fcs_err,      // fcs error
    output logic                   rx_inc_fragment,     // short with crc error
    output logic                   rx_inc_jabber,       // oversize with crc error
    output logic                   rx_inc_sizeok_fcser, // good size, fcs error
    // copies for the counter block, zero when it is not built
    output logic [`INC_W-1:0]      csr_tx_inc,          // tx counter increments
    output logic [`INC_W-1:0]      csr_rx_inc           // rx counter increments
);

    state_type state_r;
    state_type state_nxt;

    // classify one finished frame into its increment vector
    function automatic logic [`INC_W-1:0] classify(
        input logic             done,
        input logic [LEN_W-1:0] len,
        input logic             mcast,
        input logic             bcast,
        input logic             ctrl,
        input logic             pause,
        input logic             fcs
    );
        logic [`INC_W-1:0] v;
        logic              ucast;
        logic              short_f;
        logic              over_f;
        logic              good;
        v       = `INC_RST;
        ucast   = !mcast && !bcast;
        short_f = len < `LEN_64;
        over_f  = len > MAX_LEN;
        good    = !fcs;

        // size bins
        v[`INC_64]         = len == `LEN_64;
        v[`INC_127]        = len > `LEN_64 && len <= `LEN_127;
        v[`INC_255]        = len > `LEN_127 && len <= `LEN_255;
        v[`INC_511]        = len > `LEN_255 && len <= `LEN_511;
        v[`INC_1023]       = len > `LEN_511 && len <= `LEN_1023;
        v[`INC_1518]       = len > `LEN_1023 && len <= `LEN_1518;
        v[`INC_MAX]        = len == MAX_LEN;
        v[`INC_OVER]       = over_f;

        // data frames by address type and error
        v[`INC_MC_DATA_E]  = mcast && !ctrl && fcs;
        v[`INC_MC_DATA_O]  = mcast && !ctrl && good;
        v[`INC_BC_DATA_E]  = bcast && !ctrl && fcs;
        v[`INC_BC_DATA_O]  = bcast && !ctrl && good;
        v[`INC_UC_DATA_E]  = ucast && !ctrl && fcs;
        v[`INC_UC_DATA_O]  = ucast && !ctrl && good;

        // control class, any valid frame of the address type
        v[`INC_MC_CTRL]    = mcast && good;
        v[`INC_BC_CTRL]    = bcast && good;
        v[`INC_UC_CTRL]    = ucast && good;
        v[`INC_PAUSE]      = pause && good;

        // error categories
        v[`INC_FCS_ERR]    = fcs;
        v[`INC_FRAGMENT]   = short_f && fcs;
        v[`INC_JABBER]     = over_f && fcs;
        v[`INC_SIZEOK_FCS] = fcs && !short_f && !over_f;
        v[`INC_RUNT]       = short_f && good;

        // nothing is raised without a frame end
        classify = done ? v : `INC_RST;
    endfunction : classify

    // next state: one vector per direction, copies when counters exist
    always_comb begin
        state_nxt        = state_r;
        state_nxt.tx_inc = classify(tx_frame_done, tx_frame_len, tx_is_mcast, // RULE3
                                    tx_is_bcast, tx_is_ctrl, tx_is_pause,
                                    tx_fcs_err);
        // rx errors count when the mac checks, not when the client sees them
        state_nxt.rx_inc = classify(rx_frame_done, rx_frame_len, rx_is_mcast, // RULE25
                                    rx_is_bcast, rx_is_ctrl, rx_is_pause,
                                    rx_fcs_err);
        state_nxt.csr_tx = STATS_EN ? state_nxt.tx_inc : `INC_RST; // RULE2
        state_nxt.csr_rx = STATS_EN ? state_nxt.rx_inc : `INC_RST; // RULE2
    end

    // state register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    // tx outputs straight from the register
    assign tx_inc_64           = state_r.tx_inc[`INC_64];         // RULE4
    assign tx_inc_127          = state_r.tx_inc[`INC_127];        // RULE4
    assign tx_inc_255          = state_r.tx_inc[`INC_255];        // RULE5
    assign tx_inc_511          = state_r.tx_inc[`INC_511];        // RULE5
    assign tx_inc_1023         = state_r.tx_inc[`INC_1023];       // RULE6
    assign tx_inc_1518         = state_r.tx_inc[`INC_1518];       // RULE6
    assign tx_inc_max          = state_r.tx_inc[`INC_MAX];        // RULE7
    assign tx_inc_over         = state_r.tx_inc[`INC_OVER];       // RULE7

    // data frames by address type
    assign tx_inc_mcast_data_e = state_r.tx_inc[`INC_MC_DATA_E];  // RULE8
    assign tx_inc_mcast_data_o = state_r.tx_inc[`INC_MC_DATA_O];  // RULE8
    assign tx_inc_bcast_data_e = state_r.tx_inc[`INC_BC_DATA_E];  // RULE9
    assign tx_inc_bcast_data_o = state_r.tx_inc[`INC_BC_DATA_O];  // RULE9
    assign tx_inc_ucast_data_e = state_r.tx_inc[`INC_UC_DATA_E];  // RULE10
    assign tx_inc_ucast_data_o = state_r.tx_inc[`INC_UC_DATA_O];  // RULE10

    // control class and pause
    assign tx_inc_mcast_ctrl   = state_r.tx_inc[`INC_MC_CTRL];    // RULE11
    assign tx_inc_bcast_ctrl   = state_r.tx_inc[`INC_BC_CTRL];    // RULE11
    assign tx_inc_ucast_ctrl   = state_r.tx_inc[`INC_UC_CTRL];    // RULE11
    assign tx_inc_pause        = state_r.tx_inc[`INC_PAUSE];      // RULE12

    // error classes
    assign tx_inc_fcs_err      = state_r.tx_inc[`INC_FCS_ERR];    // RULE13
    assign tx_inc_fragment     = state_r.tx_inc[`INC_FRAGMENT];   // RULE14
    assign tx_inc_jabber       = state_r.tx_inc[`INC_JABBER];     // RULE15
    assign tx_inc_sizeok_fcser = state_r.tx_inc[`INC_SIZEOK_FCS]; // RULE16

    // rx outputs straight from the register
    assign rx_inc_runt         = state_r.rx_inc[`INC_RUNT];       // RULE17
    assign rx_inc_64           = state_r.rx_inc[`INC_64];         // RULE18
    assign rx_inc_127          = state_r.rx_inc[`INC_127];        // RULE18
    assign rx_inc_255          = state_r.rx_inc[`INC_255];        // RULE19
    assign rx_inc_511          = state_r.rx_inc[`INC_511];        // RULE19
    assign rx_inc_1023         = state_r.rx_inc[`INC_1023];       // RULE20
    assign rx_inc_1518         = state_r.rx_inc[`INC_1518];       // RULE20
    assign rx_inc_max          = state_r.rx_inc[`INC_MAX];        // RULE21
    assign rx_inc_over         = state_r.rx_inc[`INC_OVER];       // RULE21

    // data frames by address type
    assign rx_inc_mcast_data_e = state_r.rx_inc[`INC_MC_DATA_E];  // RULE22
    assign rx_inc_mcast_data_o = state_r.rx_inc[`INC_MC_DATA_O];  // RULE22
    assign rx_inc_bcast_data_e = state_r.rx_inc[`INC_BC_DATA_E];  // RULE22
    assign rx_inc_bcast_data_o = state_r.rx_inc[`INC_BC_DATA_O];  // RULE23
    assign rx_inc_ucast_data_e = state_r.rx_inc[`INC_UC_DATA_E];  // RULE24
    assign rx_inc_ucast_data_o = state_r.rx_inc[`INC_UC_DATA_O];  // RULE24

    // control class and pause
    assign rx_inc_mcast_ctrl   = state_r.rx_inc[`INC_MC_CTRL];
    assign rx_inc_bcast_ctrl   = state_r.rx_inc[`INC_BC_CTRL];
    assign rx_inc_ucast_ctrl   = state_r.rx_inc[`INC_UC_CTRL];
    assign rx_inc_pause        = state_r.rx_inc[`INC_PAUSE];

    // error classes
    assign rx_inc_fcs_err      = state_r.rx_inc[`INC_FCS_ERR];    // RULE25
    assign rx_inc_fragment     = state_r.rx_inc[`INC_FRAGMENT];   // RULE26
    assign rx_inc_jabber       = state_r.rx_inc[`INC_JABBER];
    assign rx_inc_sizeok_fcser = state_r.rx_inc[`INC_SIZEOK_FCS];

    // counter block copies, always present as ports
    assign csr_tx_inc = state_r.csr_tx; // RULE1
    assign csr_rx_inc = state_r.csr_rx; // RULE1

    // tx 64-byte frame gives a 64 bin pulse next cycle
    tx_bin_64_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE4
        tx_frame_done && tx_frame_len == `LEN_64
        |=> tx_inc_64 && !tx_inc_127)
        else $error("tx 64 byte bin missed");

    // tx 1024-1518 bin covers its whole range
    tx_bin_1518_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE6
        tx_frame_done && tx_frame_len > `LEN_1023 && tx_frame_len <= `LEN_1518
        |=> tx_inc_1518 && !tx_inc_1023)
        else $error("tx 1518 bin wrong");

    // tx pulses need a frame end one cycle before
    tx_once_frame_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE27
        (state_r.tx_inc != `INC_RST)
        |-> $past(tx_frame_done))
        else $error("tx pulse without frame");

    // an isolated tx fcs error pulse lasts one cycle
    tx_pulse_width_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE27
        tx_inc_fcs_err && !tx_frame_done
        |=> !tx_inc_fcs_err)
        else $error("tx pulse too long");

    // tx fragment ties short length to crc error
    tx_fragment_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE14
        tx_frame_done && tx_frame_len < `LEN_64 && tx_fcs_err
        |=> tx_inc_fragment && tx_inc_fcs_err && !tx_inc_sizeok_fcser)
        else $error("tx fragment missed");

    // tx jabber is oversize with crc error
    tx_jabber_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE15
        tx_inc_jabber
        |-> tx_inc_over && tx_inc_fcs_err)
        else $error("tx jabber without cause");

    // tx unicast errored and valid data never both pulse
    tx_data_excl_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE10
        !(tx_inc_ucast_data_e && tx_inc_ucast_data_o))
        else $error("tx unicast both classes");

    // valid pause frame gives a pause pulse
    tx_pause_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE12
        tx_frame_done && tx_is_pause && !tx_fcs_err
        |=> tx_inc_pause)
        else $error("tx pause missed");

    // rx runt is short and good
    rx_runt_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE17
        rx_frame_done && rx_frame_len < `LEN_64 && !rx_fcs_err
        |=> rx_inc_runt && !rx_inc_fragment)
        else $error("rx runt missed");

    // rx broadcast valid data pulse
    rx_bcast_valid_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE23
        rx_frame_done && rx_is_bcast && !rx_is_ctrl && !rx_fcs_err
        |=> rx_inc_bcast_data_o && !rx_inc_bcast_data_e)
        else $error("rx broadcast valid missed");

    // with counters built, the rx fcs error copy follows its top pulse
    csr_copy_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE2
        STATS_EN
        |-> csr_rx_inc[`INC_FCS_ERR] == rx_inc_fcs_err)
        else $error("counter copy differs");

    // tx crc error on a legal size frame
    tx_sizeok_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE16
        tx_frame_done && tx_fcs_err && tx_frame_len >= `LEN_64 && tx_frame_len <= MAX_LEN
        |=> tx_inc_sizeok_fcser && !tx_inc_fragment && !tx_inc_jabber)
        else $error("tx size valid fcs missed");

    // rx oversize frame is not maximum size
    rx_over_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE21
        rx_frame_done && rx_frame_len > MAX_LEN
        |=> rx_inc_over && !rx_inc_max)
        else $error("rx oversize missed");

    // rx unicast data splits on the crc result
    rx_ucast_data_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE24
        rx_frame_done && !rx_is_mcast && !rx_is_bcast && !rx_is_ctrl
        |=> rx_inc_ucast_data_e == $past(rx_fcs_err) && rx_inc_ucast_data_o != $past(rx_fcs_err))
        else $error("rx unicast data class wrong");

    // rx fragment is short with crc error
    rx_fragment_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE26
        rx_frame_done && rx_frame_len < `LEN_64 && rx_fcs_err
        |=> rx_inc_fragment && rx_inc_fcs_err && !rx_inc_runt)
        else $error("rx fragment missed");

endmodule : mac_stats_increment_pulses
`default_nettype wire

// File: tb/stat_counter_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "mac_stats_params.svh"
module stat_counter_model
    import mac_stats_pkg::*;
(
    input  wire logic              clk,       // mac clock
    input  wire logic              reset_n,   // async reset, active low
    input  wire logic [`INC_W-1:0] tx_inc,    // tx counter increments
    input  wire logic [`INC_W-1:0] rx_inc,    // rx counter increments
    output logic      [31:0]       tx_events, // sum of tx increments taken
    output logic      [31:0]       rx_events  // sum of rx increments taken
);
    // counters add increment bits up to 22, not the spares; tx has no runt counter so its bit 22 is left out
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_events <= 32'h00000000;
            rx_events <= 32'h00000000;
        end else begin
            tx_events <= tx_events + 32'($countones(tx_inc[21:0]));
            rx_events <= rx_events + 32'($countones(rx_inc[22:0]));
        end
    end
endmodule : stat_counter_model
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "mac_stats_params.svh"
module tb_top
    import mac_stats_pkg::*;
;
    localparam logic [15:0] ML = `MAX_LEN_DEF;
    logic             clk = 1'b0;
    logic             reset_n = 1'b0;
    logic             tdone = 1'b0;
    logic             rdone = 1'b0;
    logic [15:0]      tlen = 16'h0000;
    logic [15:0]      rlen = 16'h0000;
    logic [4:0]       tf = 5'h00;
    logic [4:0]       rf = 5'h00;
    wire logic [21:0] tv;
    wire logic [22:0] rv;
    wire logic [24:0] ctv;
    wire logic [24:0] crv;
    wire logic [31:0] m_tx;
    wire logic [31:0] m_rx;
    int               err_total = 0;
    int               checked = 0;
    int               exp_tx = 0;
    int               exp_rx = 0;

    // clock at 40 MHz
    always #12.5 clk = ~clk;

    // flag order in tf/rf: mcast, bcast, ctrl, pause, fcs error
    mac_stats_increment_pulses dut (.clk(clk), .reset_n(reset_n),
        .tx_frame_done(tdone), .tx_frame_len(tlen), .tx_is_mcast(tf[4]), .tx_is_bcast(tf[3]),
        .tx_is_ctrl(tf[2]), .tx_is_pause(tf[1]), .tx_fcs_err(tf[0]),
        .rx_frame_done(rdone), .rx_frame_len(rlen), .rx_is_mcast(rf[4]), .rx_is_bcast(rf[3]),
        .rx_is_ctrl(rf[2]), .rx_is_pause(rf[1]), .rx_fcs_err(rf[0]),
        .tx_inc_64(tv[0]), .tx_inc_127(tv[1]), .tx_inc_255(tv[2]), .tx_inc_511(tv[3]),
        .tx_inc_1023(tv[4]), .tx_inc_1518(tv[5]), .tx_inc_max(tv[6]), .tx_inc_over(tv[7]),
        .tx_inc_mcast_data_e(tv[8]), .tx_inc_mcast_data_o(tv[9]), .tx_inc_bcast_data_e(tv[10]),
        .tx_inc_bcast_data_o(tv[11]), .tx_inc_ucast_data_e(tv[12]), .tx_inc_ucast_data_o(tv[13]),
        .tx_inc_mcast_ctrl(tv[14]), .tx_inc_bcast_ctrl(tv[15]), .tx_inc_ucast_ctrl(tv[16]),
        .tx_inc_pause(tv[17]), .tx_inc_fcs_err(tv[18]), .tx_inc_fragment(tv[19]),
        .tx_inc_jabber(tv[20]), .tx_inc_sizeok_fcser(tv[21]), .rx_inc_runt(rv[22]),
        .rx_inc_64(rv[0]), .rx_inc_127(rv[1]), .rx_inc_255(rv[2]), .rx_inc_511(rv[3]),
        .rx_inc_1023(rv[4]), .rx_inc_1518(rv[5]), .rx_inc_max(rv[6]), .rx_inc_over(rv[7]),
        .rx_inc_mcast_data_e(rv[8]), .rx_inc_mcast_data_o(rv[9]), .rx_inc_bcast_data_e(rv[10]),
        .rx_inc_bcast_data_o(rv[11]), .rx_inc_ucast_data_e(rv[12]), .rx_inc_ucast_data_o(rv[13]),
        .rx_inc_mcast_ctrl(rv[14]), .rx_inc_bcast_ctrl(rv[15]), .rx_inc_ucast_ctrl(rv[16]),
        .rx_inc_pause(rv[17]), .rx_inc_fcs_err(rv[18]), .rx_inc_fragment(rv[19]),
        .rx_inc_jabber(rv[20]), .rx_inc_sizeok_fcser(rv[21]),
        .csr_tx_inc(ctv), .csr_rx_inc(crv));

    // counter block on the far side of the csr vectors
    stat_counter_model model (.clk(clk), .reset_n(reset_n), .tx_inc(ctv), .rx_inc(crv),
        .tx_events(m_tx), .rx_events(m_rx));

    // expected pulse vector of one frame report
    function automatic logic [24:0] expv(input logic [15:0] n, input logic [4:0] f, input bit rx);
        logic [24:0] v;
        logic        uc;
        v = 25'h0000000;
        uc = !f[4] && !f[3];
        v[`INC_64] = n == `LEN_64;
        v[`INC_127] = n > `LEN_64 && n <= `LEN_127;
        v[`INC_255] = n > `LEN_127 && n <= `LEN_255;
        v[`INC_511] = n > `LEN_255 && n <= `LEN_511;
        v[`INC_1023] = n > `LEN_511 && n <= `LEN_1023;
        v[`INC_1518] = n > `LEN_1023 && n <= `LEN_1518;
        v[`INC_MAX] = n == ML;
        v[`INC_OVER] = n > ML;
        v[`INC_MC_DATA_E] = f[4] && !f[2] && f[0];
        v[`INC_MC_DATA_O] = f[4] && !f[2] && !f[0];
        v[`INC_BC_DATA_E] = f[3] && !f[2] && f[0];
        v[`INC_BC_DATA_O] = f[3] && !f[2] && !f[0];
        v[`INC_UC_DATA_E] = uc && !f[2] && f[0];
        v[`INC_UC_DATA_O] = uc && !f[2] && !f[0];
        v[`INC_MC_CTRL] = f[4] && !f[0];
        v[`INC_BC_CTRL] = f[3] && !f[0];
        v[`INC_UC_CTRL] = uc && !f[0];
        v[`INC_PAUSE] = f[1] && !f[0];
        v[`INC_FCS_ERR] = f[0];
        v[`INC_FRAGMENT] = n < `LEN_64 && f[0];
        v[`INC_JABBER] = n > ML && f[0];
        v[`INC_SIZEOK_FCS] = f[0] && n >= `LEN_64 && n <= ML;
        v[`INC_RUNT] = rx && n < `LEN_64 && !f[0];
        return v;
    endfunction : expv

    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp

    // compare both directions and the counter copies in the cycle after the report edge
    task automatic judge(input logic [24:0] et, input logic [24:0] er);
        cmp("tx pulses", {10'h000, et[21:0]}, {10'h000, tv});
        cmp("rx pulses", {9'h000, er[22:0]}, {9'h000, rv});
        cmp("csr tx", {10'h000, et[21:0]}, {10'h000, ctv[21:0]});
        cmp("csr rx", {7'h00, er}, {7'h00, crv});
        exp_tx += $countones(et[21:0]);
        exp_rx += $countones(er[22:0]);
    endtask : judge

    task automatic put(input logic [15:0] a, input logic [4:0] b, input logic [15:0] c,
                       input logic [4:0] d);
        tdone <= 1'b1;
        tlen <= a;
        tf <= b;
        rdone <= 1'b1;
        rlen <= c;
        rf <= d;
    endtask : put

    task automatic go(input logic [15:0] a, input logic [4:0] b, input logic [15:0] c,
                      input logic [4:0] d);
        @(posedge clk);
        put(a, b, c, d);
        @(posedge clk);
        tdone <= 1'b0;
        rdone <= 1'b0;
        #1;
        judge(expv(a, b, 1'b0), expv(c, d, 1'b1));
    endtask : go

    task automatic t_bins;
        logic [15:0] l [15] = '{16'd63, 16'd64, 16'd65, 16'd127, 16'd128, 16'd255, 16'd256,
            16'd511, 16'd512, 16'd1023, 16'd1024, 16'd1517, 16'd1518, 16'd1519, 16'd2000};
        foreach (l[i]) go(l[i], 5'h00, l[i], 5'h08);
        $display("test bins done");
    endtask : t_bins

    task automatic t_addr;
        for (int f = 0; f < 32; f++) begin
            if (!(f[4] && f[3])) go(16'd100, 5'(f), 16'd64, 5'(f));
        end
        $display("test address classes done");
    endtask : t_addr

    task automatic t_err;
        logic [15:0] l [5] = '{16'd40, 16'd63, 16'd100, 16'd1518, 16'd2000};
        foreach (l[i]) go(l[i], 5'h01, l[i], 5'h11);
        foreach (l[i]) go(l[i], 5'h10, l[i], 5'h00);
        $display("test error classes done");
    endtask : t_err

    // back-to-back reports, then ignored inputs while done is low
    task automatic t_b2b;
        @(posedge clk);
        put(16'd64, 5'h08, 16'd40, 5'h01);
        @(posedge clk);
        put(16'd2000, 5'h01, 16'd1518, 5'h12);
        #1;
        judge(expv(16'd64, 5'h08, 1'b0), expv(16'd40, 5'h01, 1'b1));
        @(posedge clk);
        tdone <= 1'b0;
        rdone <= 1'b0;
        #1;
        judge(expv(16'd2000, 5'h01, 1'b0), expv(16'd1518, 5'h12, 1'b1));
        @(posedge clk);
        #1;
        judge(25'h0000000, 25'h0000000);
        cmp("tx events", 32'(exp_tx), m_tx);
        cmp("rx events", 32'(exp_rx), m_rx);
        $display("test back to back done");
    endtask : t_b2b

    // reset in mid-run clears a pending pulse at once
    task automatic t_reset;
        @(posedge clk);
        put(16'd64, 5'h00, 16'd64, 5'h00);
        @(posedge clk);
        reset_n <= 1'b0;
        tdone <= 1'b0;
        rdone <= 1'b0;
        #1;
        judge(25'h0000000, 25'h0000000);
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        #1;
        judge(25'h0000000, 25'h0000000);
        $display("test reset done");
    endtask : t_reset

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : conclude

    // watchdog well beyond the roughly 115 cycles of the tests
    initial begin
        #(25 * 5000);
        err_total++;
        conclude();
    end

    initial begin
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        t_bins();
        t_addr();
        t_err();
        t_b2b();
        t_reset();
        conclude();
    end
endmodule : tb_top
`default_nettype wire
